//--- hdl/wmr_pkg.sv
// Constants and types shared by the weather register bank
// Summary of operation
// - Humidity over 95% for an hour: latch readings, heat 5 minutes.
// - After a burst wait 15 minutes; still humid: latch, heat again.
// - Dry at the check: end cycle, need another full humid hour.
// - Refresh readings every 20 minutes while active, else every 2 seconds.
// - Status bit 0 shows the heater on.
// - Status bit 1 is 0 for the slow rate, 1 for fast.
// - Humid hour is timed whatever the coil; latching and heating only while the enable coil is 1; bit 2 mirrors the coil.
// - Answer only slave address 14.
// - Measurements read as input registers with function 04.
// - Coils are 0 after reset.
// - Input registers are 16 bits wide.
// - Register number minus 30001 is the input register address.
// - Coil number minus 1 is the coil address; heater coil at 0.
// - Fractions held as integers scaled by 10 or 100.
// - Register 13 holds the backup temperature, same encoding.
// - Primary temperature from humidity sensor, frozen between slow updates while active, refreshed every 2 seconds when idle.
package wmr_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam logic [7:0] SLAVE_ADDR = 8'h0E;
   localparam logic [7:0] FN_READ_INPUT = 8'h04;
   localparam logic [7:0] FN_WRITE_COIL = 8'h05;
   localparam logic [7:0] EX_FUNC = 8'h01;
   localparam logic [7:0] EX_ADDR = 8'h02;
   localparam logic [7:0] EX_VALUE = 8'h03;
   localparam logic [15:0] COIL_ON = 16'hFF00;
   localparam logic [15:0] COIL_OFF = 16'h0000;
   localparam logic [15:0] COIL_HEATER = 16'h0000;
   localparam logic [15:0] REG_ID = 16'h0000;
   localparam logic [15:0] REG_WIND_HEADING = 16'h0001;
   localparam logic [15:0] REG_WIND_SPEED_AVG = 16'h0002;
   localparam logic [15:0] REG_WIND_PEAK = 16'h0003;
   localparam logic [15:0] REG_PRIMARY_TEMP = 16'h0004;
   localparam logic [15:0] REG_RAIN_ONE_HOUR = 16'h0005;
   localparam logic [15:0] REG_RAIN_ONE_DAY = 16'h0006;
   localparam logic [15:0] REG_RAIN_TODAY = 16'h0007;
   localparam logic [15:0] REG_HUMIDITY = 16'h0008;
   localparam logic [15:0] REG_AIR_PRESSURE = 16'h0009;
   localparam logic [15:0] REG_LIGHT_LEVEL = 16'h000A;
   localparam logic [15:0] REG_SNOWFALL = 16'h000B;
   localparam logic [15:0] REG_RAIN_RAW = 16'h000C;
   localparam logic [15:0] REG_BACKUP_TEMP = 16'h000D;
   localparam logic [15:0] REG_STATUS = 16'h000E;
   localparam int ST_HEATER = 0;
   localparam int ST_FAST = 1;
   localparam int ST_ENABLE = 2;
   // Percent times 100
   localparam logic [15:0] HUM_LIMIT = 16'h251C;
   localparam int HUMID_S = 3600;
   localparam int BURST_S = 5 * 60;
   localparam int COOL_S = 15 * 60;
   localparam int SLOW_S = 20 * 60;
   localparam int FAST_S = 2;
   localparam logic [15:0] ID_VALUE = 16'h1234; // Value is arbitrary
   typedef enum logic [1:0] {WMR_IDLE, WMR_LATCH, WMR_BURST, WMR_COOL} wmr_state_t;
   typedef struct packed {
      wmr_state_t st;
      logic coil;
      logic heater;
      logic [31:0] pre;
      logic [11:0] secCnt;
      logic [11:0] humidCnt;
      logic [10:0] refCnt;
      logic [15:0] temp;
      logic [15:0] hum;
      logic rspValid;
      logic rspErr;
      logic [7:0] rspFunc;
      logic [15:0] rspData;
   } wmr_regs_t;
endpackage

//--- hdl/wmr_heater_regs.sv
// Modbus input register bank, heater coil and heater sequencer
`timescale 1ns/1ps
`default_nettype none
module wmr_heater_regs #(
   parameter int CYCLES_PER_SEC = wmr_pkg::CLK_HZ,
   parameter logic [15:0] DEVICE_IDENTIFIER = wmr_pkg::ID_VALUE
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   // Decoded request frame from the RTU framer
   input wire logic reqValid,
   input wire logic [7:0] reqSlave,
   input wire logic [7:0] reqFunc,
   input wire logic [15:0] reqAddr,
   input wire logic [15:0] reqData,
   output logic rspValid,
   output logic rspErr,
   output logic [7:0] rspFunc,
   output logic [15:0] rspData,
   // Live readings from the sensor logic, already scaled
   input wire logic [15:0] sensorTemperature,
   input wire logic [15:0] sensorHumidity,
   input wire logic [15:0] backupTemperature,
   input wire logic [15:0] windHeading,
   input wire logic [15:0] windSpeedAvg,
   input wire logic [15:0] windPeak,
   input wire logic [15:0] rainOneHour,
   input wire logic [15:0] rainOneDay,
   input wire logic [15:0] airPressure,
   input wire logic [15:0] lightLevel,
   input wire logic [15:0] rainRawCount,
   output logic heaterOn
);

   // The prescaler cannot divide by less than one
   if (CYCLES_PER_SEC < 1) begin : gBadRate
      $error("CYCLES_PER_SEC must be at least 1");
   end

   localparam logic [31:0] PRE_LAST = 32'(CYCLES_PER_SEC - 1);
   localparam logic [11:0] HUMID_LAST = 12'(wmr_pkg::HUMID_S);
   localparam logic [11:0] BURST_LAST = 12'(wmr_pkg::BURST_S - 1);
   localparam logic [11:0] COOL_LAST = 12'(wmr_pkg::COOL_S - 1);
   localparam logic [10:0] SLOW_LAST = 11'(wmr_pkg::SLOW_S - 1);
   localparam logic [10:0] FAST_LAST = 11'(wmr_pkg::FAST_S - 1);

   wmr_pkg::wmr_regs_t r;
   wmr_pkg::wmr_regs_t next_r;
   logic secTick;
   logic humid;
   logic active;
   logic [15:0] statusWord;
   logic [15:0] readWord;
   logic readHit;

   ////////////////////////////////////////////////////////////////////////
   // Read map

   always_comb begin
      humid = sensorHumidity > wmr_pkg::HUM_LIMIT;
      active = r.st != wmr_pkg::WMR_IDLE;
      statusWord = 16'h0000;
      statusWord[wmr_pkg::ST_HEATER] = r.heater;
      statusWord[wmr_pkg::ST_FAST] = !active;
      statusWord[wmr_pkg::ST_ENABLE] = r.coil;
      readHit = 1'b1;
      readWord = 16'h0000;
      // Every word is 16 bits; readings are scaled upstream by 10 or 100
      unique case (reqAddr)
         wmr_pkg::REG_ID: begin
            readWord = DEVICE_IDENTIFIER;
         end
         wmr_pkg::REG_WIND_HEADING: begin
            readWord = windHeading;
         end
         wmr_pkg::REG_WIND_SPEED_AVG: begin
            readWord = windSpeedAvg;
         end
         wmr_pkg::REG_WIND_PEAK: begin
            readWord = windPeak;
         end
         wmr_pkg::REG_PRIMARY_TEMP: begin
            readWord = r.temp;
         end
         wmr_pkg::REG_RAIN_ONE_HOUR: begin
            readWord = rainOneHour;
         end
         wmr_pkg::REG_RAIN_ONE_DAY: begin
            readWord = rainOneDay;
         end
         wmr_pkg::REG_RAIN_TODAY: begin
            readWord = 16'h0000;
         end
         wmr_pkg::REG_HUMIDITY: begin
            readWord = r.hum;
         end
         wmr_pkg::REG_AIR_PRESSURE: begin
            readWord = airPressure;
         end
         wmr_pkg::REG_LIGHT_LEVEL: begin
            readWord = lightLevel;
         end
         wmr_pkg::REG_SNOWFALL: begin
            readWord = 16'h0000;
         end
         wmr_pkg::REG_RAIN_RAW: begin
            readWord = rainRawCount;
         end
         wmr_pkg::REG_BACKUP_TEMP: begin
            readWord = backupTemperature;
         end
         wmr_pkg::REG_STATUS: begin
            readWord = statusWord;
         end
         default: begin
            readHit = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      next_r = r;
      next_r.rspValid = 1'b0;
      secTick = r.pre == PRE_LAST;
      next_r.pre = secTick ? 32'h00000000 : r.pre + 32'h00000001;

      // Requests to other slaves pass silently, as on a shared line
      if (reqValid && reqSlave == wmr_pkg::SLAVE_ADDR) begin
         next_r.rspValid = 1'b1;
         next_r.rspFunc = reqFunc;
         next_r.rspErr = 1'b0;
         next_r.rspData = 16'h0000;
         if (reqFunc == wmr_pkg::FN_READ_INPUT) begin
            next_r.rspErr = !readHit;
            next_r.rspData = readHit ? readWord : {8'h00, wmr_pkg::EX_ADDR};
         end else if (reqFunc == wmr_pkg::FN_WRITE_COIL) begin
            if (reqAddr != wmr_pkg::COIL_HEATER) begin
               next_r.rspErr = 1'b1;
               next_r.rspData = {8'h00, wmr_pkg::EX_ADDR};
            end else if (reqData == wmr_pkg::COIL_ON) begin
               next_r.coil = 1'b1;
               next_r.rspData = reqData;
            end else if (reqData == wmr_pkg::COIL_OFF) begin
               next_r.coil = 1'b0;
               next_r.rspData = reqData;
            end else begin
               next_r.rspErr = 1'b1;
               next_r.rspData = {8'h00, wmr_pkg::EX_VALUE};
            end
         end else begin
            next_r.rspErr = 1'b1;
            next_r.rspData = {8'h00, wmr_pkg::EX_FUNC};
         end
      end

      // Reading refresh at the rate the sequencer allows
      if (secTick) begin
         if (r.refCnt >= (active ? SLOW_LAST : FAST_LAST)) begin
            next_r.refCnt = 11'h000;
            next_r.temp = sensorTemperature;
            next_r.hum = sensorHumidity;
         end else begin
            next_r.refCnt = r.refCnt + 11'h001;
         end
      end

      // Any break in high humidity restarts the hour
      if (!humid) begin
         next_r.humidCnt = 12'h000;
      end else if (secTick && r.humidCnt != HUMID_LAST) begin
         next_r.humidCnt = r.humidCnt + 12'h001;
      end

      unique case (r.st)
         wmr_pkg::WMR_IDLE: begin
            next_r.heater = 1'b0;
            next_r.secCnt = 12'h000;
            // Strictly over one hour: count saturates, then one more second
            if (r.coil && humid && secTick && r.humidCnt == HUMID_LAST) begin
               next_r.st = wmr_pkg::WMR_LATCH;
            end
         end
         wmr_pkg::WMR_LATCH: begin
            // Readings taken with the sensor at ambient, before heating
            next_r.temp = sensorTemperature;
            next_r.hum = sensorHumidity;
            next_r.refCnt = 11'h000;
            next_r.secCnt = 12'h000;
            next_r.heater = 1'b1;
            next_r.st = wmr_pkg::WMR_BURST;
         end
         wmr_pkg::WMR_BURST: begin
            if (secTick) begin
               next_r.secCnt = r.secCnt + 12'h001;
               if (r.secCnt == BURST_LAST) begin
                  next_r.heater = 1'b0;
                  next_r.secCnt = 12'h000;
                  next_r.st = wmr_pkg::WMR_COOL;
               end
            end
         end
         wmr_pkg::WMR_COOL: begin
            if (secTick) begin
               next_r.secCnt = r.secCnt + 12'h001;
               if (r.secCnt == COOL_LAST) begin
                  next_r.secCnt = 12'h000;
                  if (humid) begin
                     next_r.st = wmr_pkg::WMR_LATCH;
                  end else begin
                     next_r.st = wmr_pkg::WMR_IDLE;
                     next_r.humidCnt = 12'h000;
                  end
               end
            end
         end
      endcase

      // Dropping the coil stops heating at once
      if (!r.coil) begin
         next_r.st = wmr_pkg::WMR_IDLE;
         next_r.heater = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r <= '0;
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign rspValid = r.rspValid;
   assign rspErr = r.rspErr;
   assign rspFunc = r.rspFunc;
   assign rspData = r.rspData;
   assign heaterOn = r.heater;

endmodule
`default_nettype wire

//--- dv/wmr_heater_regs_assertions.sv
// Port checker of the weather register bank
`timescale 1ns/1ps
`default_nettype none
module wmr_heater_regs_assertions #(
   parameter int CYCLES_PER_SEC = 4,
   parameter logic [15:0] DEVICE_IDENTIFIER = 16'h0000
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic reqValid,
   input wire logic [7:0] reqSlave,
   input wire logic [7:0] reqFunc,
   input wire logic [15:0] reqAddr,
   input wire logic [15:0] reqData,
   input wire logic rspValid,
   input wire logic rspErr,
   input wire logic [7:0] rspFunc,
   input wire logic [15:0] rspData,
   input wire logic [15:0] backupTemperature,
   input wire logic heaterOn
);
   logic tk;
   logic rd;
   logic wr;
   logic [31:0] runLen;
   logic cutOff;
   assign tk = ce && reqValid && reqSlave == wmr_pkg::SLAVE_ADDR;
   assign rd = tk && reqFunc == wmr_pkg::FN_READ_INPUT;
   assign wr = tk && reqFunc == wmr_pkg::FN_WRITE_COIL && reqAddr == wmr_pkg::COIL_HEATER;
   // Clearing the coil may legally cut a burst short
   assign cutOff = wr && reqData == wmr_pkg::COIL_OFF;
   // Heater run length; frozen with ce so a stalled clock does not stretch it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) runLen <= '0;
      else if (ce) runLen <= heaterOn ? runLen + 32'h1 : '0;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   answer_next_a: assert property (tk |=> rspValid) else $error("no answer");
   foreign_quiet_a: assert property (ce && !tk |=> !rspValid)
      else $error("stray answer");
   read_ok_a: assert property (rd && reqAddr <= wmr_pkg::REG_STATUS |=>
      !rspErr && rspFunc == wmr_pkg::FN_READ_INPUT) else $error("read refused");
   read_range_a: assert property (rd && reqAddr > wmr_pkg::REG_STATUS |=>
      rspErr && rspData == 16'h0002) else $error("bad address accepted");
   bad_func_a: assert property (tk && !rd && reqFunc != wmr_pkg::FN_WRITE_COIL |=>
      rspErr && rspData == 16'h0001) else $error("bad function accepted");
   id_fixed_a: assert property (rd && reqAddr == wmr_pkg::REG_ID |=>
      rspData == DEVICE_IDENTIFIER) else $error("identifier wrong");
   backup_temp_a: assert property (rd && reqAddr == wmr_pkg::REG_BACKUP_TEMP |=>
      rspData == $past(backupTemperature)) else $error("backup temperature wrong");
   status_heater_a: assert property (rd && reqAddr == wmr_pkg::REG_STATUS |=>
      rspData[wmr_pkg::ST_HEATER] == $past(heaterOn)) else $error("heater bit wrong");
   coil_echo_a: assert property (wr && reqData[7:0] == 8'h00
      && (reqData[15:8] == 8'hFF || reqData[15:8] == 8'h00) |=> !rspErr
      && rspData == $past(reqData)) else $error("coil write not echoed");
   coil_off_a: assert property (cutOff ##1 ce |=> !heaterOn)
      else $error("heater on with coil off");
   // The one-cycle latch before heating is taken out of the burst
   burst_len_a: assert property ($fell(heaterOn) && !$past(cutOff, 2) |->
      runLen == wmr_pkg::BURST_S * CYCLES_PER_SEC - 1) else $error("burst length wrong");
   cover property (rd ##1 rspErr);
   cover property ($rose(heaterOn));
   cover property (wr ##1 !rspErr);
endmodule
bind wmr_heater_regs wmr_heater_regs_assertions #(.CYCLES_PER_SEC(CYCLES_PER_SEC),
   .DEVICE_IDENTIFIER(DEVICE_IDENTIFIER)) u_chk (.clk(clk), .reset_n(reset_n), .ce(ce), .reqValid(reqValid),
   .reqSlave(reqSlave), .reqFunc(reqFunc), .reqAddr(reqAddr), .reqData(reqData),
   .rspValid(rspValid), .rspErr(rspErr), .rspFunc(rspFunc), .rspData(rspData),
   .backupTemperature(backupTemperature), .heaterOn(heaterOn));
`default_nettype wire

//--- dv/wmr_master_model.sv
// Bus master model issuing decoded request frames
`timescale 1ns/1ps
`default_nettype none
module wmr_master_model (
   input wire logic clk,
   input wire logic rspValid,
   input wire logic rspErr,
   input wire logic [7:0] rspFunc,
   input wire logic [15:0] rspData,
   output logic reqValid,
   output logic [7:0] reqSlave,
   output logic [7:0] reqFunc,
   output logic [15:0] reqAddr,
   output logic [15:0] reqData
);
   initial begin
      reqValid = 1'b0;
      {reqSlave, reqFunc, reqAddr, reqData} = '1;
   end
   // Caller picks any slave and function code, not only slave 14 and function 04 or 05
   task automatic xfer(input logic [7:0] s, f, input logic [15:0] a, d, output logic [25:0] r);
      @(posedge clk);
      #1;
      {reqValid, reqSlave, reqFunc, reqAddr, reqData} = {1'b1, s, f, a, d};
      @(posedge clk);
      #1;
      // Released lines show the inverse so a stale frame never looks valid
      {reqValid, reqSlave, reqFunc, reqAddr, reqData} = {1'b0, ~s, ~f, ~a, ~d};
      r = {rspValid, rspErr, rspFunc, rspData};
   endtask
endmodule
`default_nettype wire

//--- dv/wmr_heater_regs_tb_top.sv
// Testbench of the weather register bank and heater sequencer
`timescale 1ns/1ps
`default_nettype none
module wmr_heater_regs_tb_top;
   localparam int CPS = 4;
   localparam logic [15:0] ID = 16'hA5C3; // Value is arbitrary
   localparam logic [7:0] S = wmr_pkg::SLAVE_ADDR;
   localparam logic [7:0] RD = wmr_pkg::FN_READ_INPUT;
   localparam logic [7:0] WR = wmr_pkg::FN_WRITE_COIL;
   logic clk, resetN, ceOn, rv, re, hOn, rqV, mCoil, mHeat, mFast;
   logic [7:0] rf, rqS, rqF;
   logic [15:0] rd, rqA, rqD, mTemp, mHum;
   logic [15:0] live [0:15];
   int n_mismatch = 0, cmp_count = 0, cyc = 0, seed, i, n;
   wmr_heater_regs #(.CYCLES_PER_SEC(CPS), .DEVICE_IDENTIFIER(ID)) u_wmr_heater_regs (.clk(clk),
      .reset_n(resetN), .ce(ceOn), .reqValid(rqV), .reqSlave(rqS), .reqFunc(rqF),
      .reqAddr(rqA), .reqData(rqD), .rspValid(rv), .rspErr(re), .rspFunc(rf), .rspData(rd),
      .sensorTemperature(live[4]), .sensorHumidity(live[8]), .backupTemperature(live[13]),
      .windHeading(live[1]), .windSpeedAvg(live[2]), .windPeak(live[3]),
      .rainOneHour(live[5]), .rainOneDay(live[6]), .airPressure(live[9]),
      .lightLevel(live[10]), .rainRawCount(live[12]), .heaterOn(hOn));
   wmr_master_model u_wmr_master_model (.clk(clk), .rspValid(rv), .rspErr(re), .rspFunc(rf),
      .rspData(rd), .reqValid(rqV), .reqSlave(rqS), .reqFunc(rqF), .reqAddr(rqA), .reqData(rqD));
   task automatic end_of_test();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [25:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Expected answer; status mirrors the bench's own view of the sequencer
   function automatic logic [25:0] model(input logic [7:0] f, input logic [15:0] a, d);
      logic [15:0] v;
      v = a == 16'h0004 ? mTemp : a == 16'h0008 ? mHum : live[a[3:0]];
      if (a == wmr_pkg::REG_STATUS) v = {13'h0000, mCoil, mFast, mHeat};
      if (f == RD) return a > 16'h000E ? {2'b11, f, 16'h0002} : {2'b10, f, v};
      if (f != WR) return {2'b11, f, 16'h0001};
      if (a != 16'h0000) return {2'b11, f, 16'h0002};
      if (d != wmr_pkg::COIL_ON && d != wmr_pkg::COIL_OFF) return {2'b11, f, 16'h0003};
      mCoil = d == wmr_pkg::COIL_ON;
      return {2'b10, f, d};
   endfunction
   task automatic req(input logic [7:0] s, f, input logic [15:0] a, d);
      logic [25:0] r;
      u_wmr_master_model.xfer(s, f, a, d, r);
      if (s == S && ceOn) chk("answer", r, model(f, a, d));
      else chk("valid", {25'h0, r[25]}, 26'h0);
   endtask
   task automatic waitHeat(input logic lvl, input int lim);
      n = 0;
      while (hOn !== lvl && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   task automatic rst();
      resetN = 1'b0;
      repeat (5) @(posedge clk);
      #1;
      resetN = 1'b1;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   initial begin
      {resetN, ceOn, mCoil, mHeat, mFast, mTemp, mHum} = {5'b01001, 32'h0};
      seed = 24330;
      for (i = 0; i < 16; i++) live[i] = 16'h0000;
      live[0] = ID;
      rst();
      req(S, WR, 16'h0000, wmr_pkg::COIL_ON);
      rst();
      mCoil = 1'b0;
      req(S, RD, wmr_pkg::REG_STATUS, 16'h0000);
      for (i = 1; i < 14; i++) if (i != 7 && i != 11) live[i] = 16'($random(seed));
      live[8] = 16'h2454;
      {mTemp, mHum} = {live[4], live[8]};
      repeat (3 * CPS) @(posedge clk);
      #1;
      for (i = 0; i < 16; i++) req(S, RD, i[15:0], 16'h0000);
      req(S, 8'h03, 16'h0000, 16'h0000);
      req(8'h0D, RD, 16'h0000, 16'h0000);
      req(S, WR, 16'h0001, wmr_pkg::COIL_ON);
      req(S, WR, 16'h0000, 16'h1234);
      // Let the last answer pulse end before the clock enable freezes it
      @(posedge clk);
      #1;
      ceOn = 1'b0;
      req(S, RD, 16'h0000, 16'h0000);
      ceOn = 1'b1;
      req(S, WR, 16'h0000, wmr_pkg::COIL_ON);
      live[8] = 16'h251D; // One count over the limit
      waitHeat(1'b1, 3700 * CPS);
      chk("humid wait", n >= 3600 * CPS && n <= 3602 * CPS + 2, 1);
      {mHeat, mFast, mHum} = {2'b10, live[8]};
      live[4] = 16'($random(seed));
      req(S, RD, wmr_pkg::REG_PRIMARY_TEMP, 16'h0000);
      req(S, RD, wmr_pkg::REG_HUMIDITY, 16'h0000);
      req(S, RD, wmr_pkg::REG_STATUS, 16'h0000);
      waitHeat(1'b0, 400 * CPS);
      mHeat = 1'b0;
      req(S, RD, wmr_pkg::REG_STATUS, 16'h0000);
      waitHeat(1'b1, 1000 * CPS);
      chk("cool wait", n >= 900 * CPS - 4 && n <= 901 * CPS + 2, 1);
      {mHeat, mTemp} = {1'b1, live[4]};
      req(S, RD, wmr_pkg::REG_PRIMARY_TEMP, 16'h0000);
      live[8] = 16'h251C; // Exactly at the limit counts as dry
      waitHeat(1'b0, 400 * CPS);
      waitHeat(1'b1, 1000 * CPS);
      chk("dry hold", n, 1000 * CPS);
      {mHeat, mFast} = 2'b01;
      req(S, RD, wmr_pkg::REG_STATUS, 16'h0000);
      req(S, WR, 16'h0000, wmr_pkg::COIL_OFF);
      req(S, RD, wmr_pkg::REG_STATUS, 16'h0000);
      end_of_test();
   end
endmodule
`default_nettype wire
